// ---- verilog/fifo_host_pkg.sv ----
// constants, register map and state types of the strobe fifo controller
// assumes a 100 MHz clock and one fifo channel driven through its pins

package fifo_host_pkg;

   // clock and pin timing, nanoseconds as printed
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_PULSE_NS    = 12;   // strobe and clear pulse width
   localparam int T_RSR_NS      = 8;    // clear recovery window
   localparam int T_ACCESS_NS   = 12;   // read low to data valid
   localparam int T_FLAG_NS     = 17;   // slowest flag change after a strobe
   localparam int T_RTF_NS      = 20;   // replay low to flags valid
   localparam int SYNC_STAGES   = 2;

   // least time rounded up to whole cycles, never below one
   function automatic int cycOf(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam logic [3:0] PULSE_CYC  = 4'(cycOf(T_PULSE_NS));
   localparam logic [3:0] RSR_CYC    = 4'(cycOf(T_RSR_NS));
   localparam logic [3:0] READ_CYC   = 4'(cycOf(T_ACCESS_NS) + SYNC_STAGES);
   localparam logic [3:0] SETTLE_CYC = 4'(cycOf(T_FLAG_NS) + SYNC_STAGES);
   localparam logic [3:0] RT_SETTLE  = 4'(cycOf(T_RTF_NS) + SYNC_STAGES);
   localparam logic [3:0] CNT_ONE    = 4'h1;

   // register offsets of the command port
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_PUSH   = 8'h08;
   localparam logic [7:0] REG_POP    = 8'h0C;

   // control bits
   localparam int CTRL_CLEAR  = 0;
   localparam int CTRL_REPLAY = 1;
   localparam int CTRL_EXPAND = 2;
   localparam int CTRL_HEAD   = 3;
   // status bits
   localparam int ST_EMPTY_N  = 0;
   localparam int ST_FULL_N   = 1;
   localparam int ST_HALF_N   = 2;
   localparam int ST_BUSY     = 3;
   localparam int ST_READY    = 4;
   localparam int ST_REFUSED  = 5;

   // synchroniser layout: nine data bits then the three flags
   localparam int SY_EMPTY = 9;
   localparam int SY_FULL  = 10;
   localparam int SY_HALF  = 11;

   typedef enum logic [8:0] {
      S_IDLE    = 9'h001,
      S_CLR_LOW = 9'h002,
      S_CLR_REC = 9'h004,
      S_WR_LOW  = 9'h008,
      S_WR_REC  = 9'h010,
      S_RD_LOW  = 9'h020,
      S_RD_REC  = 9'h040,
      S_RT_LOW  = 9'h080,
      S_RT_REC  = 9'h100
   } state_t;

   typedef struct packed {
      state_t      st;
      logic [3:0]  cnt;
      logic        clrN;
      logic        wrN;
      logic        rdN;
      logic        rtN;
      logic [8:0]  wrWord;
      logic [8:0]  rdWord;
      logic        expMode;
      logic        headSel;
      logic        ready;
      logic        refused;
      logic [11:0] meta;
      logic [11:0] sync;
      logic [31:0] rdata;
   } regs_t;

endpackage

// ---- verilog/fifo_host.sv ----
// controller that drives one strobe fifo channel through its pins
// assumes the fifo pins sit outside the clock domain; software uses a
// plain address / strobe port with read data one cycle later
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module fifo_host
   import fifo_host_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // command port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wrData,
   input  wire logic        wrStb,
   input  wire logic        rdStb,
   output logic      [31:0] rdData,
   // fifo strobes and data
   output logic             clearStrobeN,
   output logic             writeStrobeN,
   output logic      [8:0]  writeWordBus,
   output logic             readStrobeN,
   input  wire logic [8:0]  readWordBus,
   // fifo flags
   input  wire logic        emptyIndicatorN,
   input  wire logic        fullIndicatorN,
   input  wire logic        halfFullIndicatorN,
   // shared head-select / replay pin and chain input
   output logic             headReplayN,
   output logic             chainInputN,
   output logic             chainInputOeN
);

   localparam regs_t REGS_RST = '{
      st: S_CLR_LOW, cnt: PULSE_CYC - CNT_ONE, clrN: 1'b0, wrN: 1'b1,
      rdN: 1'b1, rtN: 1'b1, wrWord: 9'h000, rdWord: 9'h000,
      expMode: 1'b0, headSel: 1'b0, ready: 1'b0, refused: 1'b0,
      meta: 12'h000, sync: 12'h000, rdata: 32'h0000_0000};

   regs_t q;
   regs_t d;

   logic goClr;
   logic goRt;
   logic goPush;
   logic goPop;
   logic idle;
   logic cntDone;

   // command decode from the port
   assign idle    = (q.st == S_IDLE);
   assign cntDone = (q.cnt == 4'h0);
   assign goClr   = wrStb && addr == REG_CTRL && wrData[CTRL_CLEAR];
   assign goRt    = wrStb && addr == REG_CTRL && wrData[CTRL_REPLAY];
   assign goPush  = wrStb && addr == REG_PUSH;
   assign goPop   = wrStb && addr == REG_POP;

   // next state of the whole controller
   always_comb begin
      d       = q;
      d.meta  = {halfFullIndicatorN, fullIndicatorN, emptyIndicatorN,
                 readWordBus};
      d.sync  = q.meta;
      d.rdata = 32'h0000_0000;
      if (!cntDone) begin
         d.cnt = q.cnt - CNT_ONE;
      end
      // register reads, answered next cycle
      if (rdStb) begin
         case (addr)
            REG_CTRL: begin
               d.rdata[CTRL_EXPAND] = q.expMode;
               d.rdata[CTRL_HEAD]   = q.headSel;
            end
            REG_STATUS: begin
               d.rdata[ST_EMPTY_N] = q.sync[SY_EMPTY];
               d.rdata[ST_FULL_N]  = q.sync[SY_FULL];
               d.rdata[ST_HALF_N]  = q.sync[SY_HALF];
               d.rdata[ST_BUSY]    = !idle;
               d.rdata[ST_READY]   = q.ready;
               d.rdata[ST_REFUSED] = q.refused;
            end
            REG_POP: begin
               d.rdata[8:0] = q.rdWord;
            end
            default: begin
               d.rdata = 32'h0000_0000;
            end
         endcase
      end
      // software clears the sticky refusal; a new refusal below wins
      if (wrStb && addr == REG_STATUS && wrData[ST_REFUSED]) begin
         d.refused = 1'b0;
      end
      // mode bits change only while idle so no pulse is cut short
      if (wrStb && addr == REG_CTRL && idle) begin
         d.expMode = wrData[CTRL_EXPAND];
         d.headSel = wrData[CTRL_HEAD];
      end
      case (q.st)
         S_IDLE: begin
            if (goClr) begin
               d.st    = S_CLR_LOW;
               d.clrN  = 1'b0;
               d.ready = 1'b0;
               d.cnt   = PULSE_CYC - CNT_ONE;
            end else if (goRt) begin
               if (q.ready && !q.expMode && !wrData[CTRL_EXPAND]) begin
                  d.st  = S_RT_LOW;
                  d.rtN = 1'b0;
                  d.cnt = PULSE_CYC - CNT_ONE;
               end else begin
                  d.refused = 1'b1;
               end
            end else if (goPush) begin
               if (q.ready && q.sync[SY_FULL]) begin
                  d.st     = S_WR_LOW;
                  d.wrN    = 1'b0;
                  d.wrWord = wrData[8:0];
                  d.cnt    = PULSE_CYC - CNT_ONE;
               end else begin
                  d.refused = 1'b1;
               end
            end else if (goPop) begin
               if (q.ready && q.sync[SY_EMPTY]) begin
                  d.st  = S_RD_LOW;
                  d.rdN = 1'b0;
                  d.cnt = READ_CYC - CNT_ONE;
               end else begin
                  d.refused = 1'b1;
               end
            end
         end
         S_CLR_LOW: begin
            if (cntDone) begin
               d.st   = S_CLR_REC;
               d.clrN = 1'b1;
               d.cnt  = RSR_CYC - CNT_ONE;
            end
         end
         S_CLR_REC: begin
            if (cntDone) begin
               d.st    = S_IDLE;
               d.ready = 1'b1;
            end
         end
         S_WR_LOW: begin
            if (cntDone) begin
               d.st  = S_WR_REC;
               d.wrN = 1'b1;
               d.cnt = SETTLE_CYC - CNT_ONE;
            end
         end
         S_RD_LOW: begin
            if (cntDone) begin
               d.st     = S_RD_REC;
               d.rdN    = 1'b1;
               d.rdWord = q.sync[8:0];
               d.cnt    = SETTLE_CYC - CNT_ONE;
            end
         end
         S_RT_LOW: begin
            if (cntDone) begin
               d.st  = S_RT_REC;
               d.rtN = 1'b1;
               d.cnt = RT_SETTLE - CNT_ONE;
            end
         end
         S_WR_REC, S_RD_REC, S_RT_REC: begin
            if (cntDone) begin
               d.st = S_IDLE;
            end
         end
         default: begin
            d = REGS_RST;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= REGS_RST;
      end else begin
         q <= d;
      end
   end

   // pin drive from flops
   assign rdData        = q.rdata;
   assign clearStrobeN  = q.clrN;
   assign writeStrobeN  = q.wrN;
   assign writeWordBus  = q.wrWord;
   assign readStrobeN   = q.rdN;
   // shared pin: chain head mark in expansion, replay otherwise
   assign headReplayN   = q.expMode ? !q.headSel : q.rtN;
   // single mode pulls the chain input low; expansion releases it
   assign chainInputN   = 1'b0;
   assign chainInputOeN = q.expMode;

   // checks on the pin sequences
   a_clear_strobes_high: assert property (
      @(posedge clk) disable iff (!rst_n)
      !q.clrN |-> q.wrN && q.rdN)
      else $error("strobe low while clear is asserted");

   a_clear_recovery: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(q.clrN) |-> (q.wrN && q.rdN) [*2])
      else $error("strobe moved inside clear recovery");

   a_write_after_clear: assert property (
      @(posedge clk) disable iff (!rst_n)
      $fell(q.wrN) |-> q.ready && $past(q.sync[SY_FULL]))
      else $error("write started before clear or while full");

   a_replay_strobes: assert property (
      @(posedge clk) disable iff (!rst_n)
      !q.rtN |-> q.wrN && q.rdN && q.clrN)
      else $error("strobe low during replay pulse");

   a_replay_expand: assert property (
      @(posedge clk) disable iff (!rst_n)
      q.expMode |-> q.rtN && headReplayN == !q.headSel)
      else $error("replay issued in expansion mode");

   a_chain_release: assert property (
      @(posedge clk) disable iff (!rst_n)
      q.expMode |-> chainInputOeN)
      else $error("chain input driven in expansion mode");

   a_write_pulse: assert property (
      @(posedge clk) disable iff (!rst_n)
      $fell(q.wrN) |-> !q.wrN [*2] ##1 q.wrN)
      else $error("write pulse not two cycles");

   a_read_capture: assert property (
      @(posedge clk) disable iff (!rst_n)
      $fell(q.rdN) |-> !q.rdN [*4] ##1 (q.rdN && q.rdWord == $past(q.sync[8:0])))
      else $error("read word not captured at strobe end");

   // refusals, pulse shapes and mode stability
   a_read_not_empty: assert property (
      @(posedge clk) disable iff (!rst_n)
      $fell(q.rdN) |-> q.ready && $past(q.sync[SY_EMPTY]))
      else $error("read started before clear or while empty");

   a_one_strobe: assert property (
      @(posedge clk) disable iff (!rst_n)
      $onehot0({!q.clrN, !q.wrN, !q.rdN, !q.rtN}))
      else $error("two fifo strobes low together");

   a_clear_pulse: assert property (
      @(posedge clk) disable iff (!rst_n)
      $fell(q.clrN) |-> !q.clrN [*2] ##1 q.clrN)
      else $error("clear pulse not two cycles");

   a_replay_pulse: assert property (
      @(posedge clk) disable iff (!rst_n)
      $fell(q.rtN) |-> !q.rtN [*2] ##1 q.rtN)
      else $error("replay pulse not two cycles");

   a_replay_settle: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(q.rtN) |-> (q.wrN && q.rdN) [*4])
      else $error("strobe moved before flags settled after replay");

   a_write_data_held: assert property (
      @(posedge clk) disable iff (!rst_n)
      !$past(q.wrN) |-> $stable(q.wrWord))
      else $error("write word moved during or at end of write pulse");

   a_mode_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      !idle && !$past(idle) |-> $stable(q.expMode) && $stable(q.headSel))
      else $error("mode bits moved while a pulse was running");

   a_chain_drive: assert property (
      @(posedge clk) disable iff (!rst_n)
      !q.expMode |-> !chainInputOeN && !chainInputN)
      else $error("chain input not driven low in single mode");

   a_ready_first: assert property (
      @(posedge clk) disable iff (!rst_n)
      !q.ready |-> q.wrN && q.rdN && q.rtN)
      else $error("strobe issued before the clear completed");

   a_refuse_full: assert property (
      @(posedge clk) disable iff (!rst_n)
      goPush && idle && !q.sync[SY_FULL] |=> q.wrN && q.refused)
      else $error("write issued to a full fifo");

   a_refuse_empty: assert property (
      @(posedge clk) disable iff (!rst_n)
      goPop && idle && !q.sync[SY_EMPTY] |=> q.rdN && q.refused)
      else $error("read issued to an empty fifo");

   a_refuse_replay: assert property (
      @(posedge clk) disable iff (!rst_n)
      goRt && !goClr && idle && q.expMode |=> q.rtN && q.refused)
      else $error("replay accepted in expansion mode");

endmodule

`default_nettype wire

// ---- verif/fifo_dev_model.sv ----
// behavioural model of one strobe fifo channel seen at its pins
// assumes strobes come from the controller; no clock of its own
`timescale 1ns/1ns
`default_nettype none
module fifo_dev_model #(parameter int DEPTH = 8) (
   // strobes and mode pins
   input  wire logic       clearN,
   input  wire logic       wrN,
   input  wire logic       rdN,
   input  wire logic       rtN,
   input  wire logic       chainInN,
   // data and flags
   input  wire logic [8:0] dIn,
   output logic      [8:0] q,
   output logic            emptyN,
   output logic            fullN,
   output logic            halfN
);
   logic [8:0] mem [DEPTH];
   logic [8:0] lastQ = '0;
   logic       wrGo  = 0;
   logic       rdGo  = 0;
   int         rp = 0, wp = 0, cnt = 0;
   logic       lastWr, lastRd;
   // clear rewinds both pointers
   always @(negedge clearN) begin
      rp = 0; wp = 0; cnt = 0;
   end
   // write starts only when not full, stores at rising strobe
   always @(negedge wrN) wrGo = clearN && (cnt < DEPTH);
   always @(posedge wrN) if (wrGo) begin
      mem[wp] = dIn;
      wp = (wp + 1) % DEPTH;
      cnt++;
      wrGo = 0;
   end
   // read starts only when not empty, pointer moves at rising strobe
   always @(negedge rdN) begin
      rdGo = clearN && (cnt > 0);
      if (rdGo) lastQ = mem[rp];
   end
   always @(posedge rdN) if (rdGo) begin
      rp = (rp + 1) % DEPTH;
      cnt--;
      rdGo = 0;
   end
   // replay only in single mode with both strobes idle
   // mode pins may move in the same step as the pulse, so let them settle
   always @(negedge rtN) begin
      #1;
      if (!rtN && !chainInN && wrN && rdN) begin
         rp = 0;
         cnt = wp;
      end
   end
   // a floating bus shows the inverse of the last word
   assign q = (!rdN && rdGo) ? lastQ : ~lastQ;
   // flags follow the pointer difference
   // a started write counts from its falling strobe, a started read too;
   // releases come when the strobe rises
   assign emptyN = ((cnt - rdGo) != 0);
   assign fullN  = ((cnt + wrGo) != DEPTH);
   // in expansion the half-full pin carries the last-location pulse
   assign lastWr = !wrN && wrGo && (wp == DEPTH - 1);
   assign lastRd = !rdN && rdGo && (rp == DEPTH - 1);
   assign halfN  = chainInN ? !(lastWr || lastRd)
                            : !((cnt + wrGo) > DEPTH / 2);
endmodule
`default_nettype wire

// ---- verif/fifo_host_tb.sv ----
// self-checking bench of the fifo controller against a fifo model
// assumes the package register map and an 8 word model fifo
`timescale 1ns/1ns
`default_nettype none
module fifo_host_tb;
   import fifo_host_pkg::*;
   localparam int D = 8;
   logic        clk, rst_n, wrStb, rdStb;
   logic [7:0]  addr;
   logic [31:0] wrData, rdData, v;
   logic [8:0]  writeWordBus, readWordBus;
   logic        clearStrobeN, writeStrobeN, readStrobeN, headReplayN;
   logic        chainInputN, chainInputOeN, chainLine;
   logic        emptyIndicatorN, fullIndicatorN, halfFullIndicatorN;
   logic [8:0]  q9[$], keep[$];
   int          seed = 4, bad_count = 0, checks_done = 0;
   // chain line has a pull-up when released
   assign chainLine = chainInputOeN ? 1'b1 : chainInputN;
   fifo_host i_fifo_host (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
      .clearStrobeN(clearStrobeN), .writeStrobeN(writeStrobeN),
      .writeWordBus(writeWordBus), .readStrobeN(readStrobeN),
      .readWordBus(readWordBus), .emptyIndicatorN(emptyIndicatorN),
      .fullIndicatorN(fullIndicatorN),
      .halfFullIndicatorN(halfFullIndicatorN), .headReplayN(headReplayN),
      .chainInputN(chainInputN), .chainInputOeN(chainInputOeN));
   fifo_dev_model #(.DEPTH(D)) i_fifo_dev_model (.clearN(clearStrobeN),
      .wrN(writeStrobeN), .rdN(readStrobeN), .rtN(headReplayN),
      .chainInN(chainLine), .dIn(writeWordBus), .q(readWordBus),
      .emptyN(emptyIndicatorN), .fullN(fullIndicatorN),
      .halfN(halfFullIndicatorN));
   // free running clock
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic wrap_up;
      $display("mismatches %0d checks %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one write cycle on the command port
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a; wrData <= d; wrStb <= 1;
      @(posedge clk);
      wrStb <= 0;
   endtask
   // one read cycle, data taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      @(posedge clk);
      addr <= a; rdStb <= 1;
      @(posedge clk);
      rdStb <= 0;
      #1 r = rdData;
   endtask
   task automatic waitIdle;
      logic [31:0] s;
      for (int i = 0; i < 40; i++) begin
         rd(REG_STATUS, s);
         if (s[ST_BUSY] === 1'b0 && s[ST_READY] === 1'b1) return;
      end
      bad_count++;
      $display("unexpected at %0t: controller stuck busy", $time);
      wrap_up;
   endtask
   // status expected with k words stored
   function automatic logic [31:0] stat(input int k, input logic rf);
      stat = 32'h0000_0010;
      stat[ST_EMPTY_N] = (k != 0);
      stat[ST_FULL_N] = (k != D);
      stat[ST_HALF_N] = !(k > D / 2);
      stat[ST_REFUSED] = rf;
   endfunction
   task automatic cmd(input logic [7:0] a, input logic [31:0] d, int k,
                      input logic rf);
      wr(a, d);
      waitIdle;
      rd(REG_STATUS, v);
      chk(v, stat(k, rf));
      if (rf) wr(REG_STATUS, 32'h0000_0020);
   endtask
   task automatic push(input int k);
      logic [8:0] w;
      w = 9'($random(seed));
      q9.push_back(w);
      cmd(REG_PUSH, {23'h0, w}, k, 1'b0);
   endtask
   task automatic pop(input int k);
      cmd(REG_POP, 32'h0000_0000, k, 1'b0);
      rd(REG_POP, v);
      chk(v, {23'h0, q9.pop_front()});
   endtask
   // main sequence
   initial begin
      rst_n = 0; wrStb = 0; rdStb = 0; addr = '0; wrData = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1;
      waitIdle;
      rd(REG_STATUS, v);
      chk(v, stat(0, 1'b0));
      cmd(REG_POP, 32'h0000_0000, 0, 1'b1);
      for (int k = 1; k <= D; k++) push(k);
      cmd(REG_PUSH, 32'h0000_01FF, D, 1'b1);
      for (int k = D - 1; k >= 0; k--) pop(k);
      push(1);
      pop(0);
      cmd(REG_CTRL, 32'h0000_0001, 0, 1'b0);
      for (int k = 1; k <= 3; k++) push(k);
      keep = q9;
      pop(2);
      pop(1);
      cmd(REG_CTRL, 32'h0000_0002, 3, 1'b0);
      q9 = keep;
      for (int k = 2; k >= 0; k--) pop(k);
      wr(REG_CTRL, 32'h0000_000C);
      rd(REG_CTRL, v);
      chk(v, 32'h0000_000C);
      chk({31'h0, chainInputOeN}, 32'h0000_0001);
      chk({31'h0, headReplayN}, 32'h0000_0000);
      cmd(REG_CTRL, 32'h0000_000E, 0, 1'b1);
      wr(REG_CTRL, 32'h0000_0000);
      waitIdle;
      chk({31'h0, chainInputOeN}, 32'h0000_0000);
      chk({31'h0, headReplayN}, 32'h0000_0001);
      // mid-run reset with words stored: the controller clears again
      push(1);
      push(2);
      @(posedge clk);
      rst_n <= 0;
      repeat (2) @(posedge clk);
      chk({31'h0, clearStrobeN}, 32'h0000_0000);
      chk({31'h0, writeStrobeN & readStrobeN}, 32'h0000_0001);
      rst_n <= 1;
      q9.delete();
      waitIdle;
      rd(REG_STATUS, v);
      chk(v, stat(0, 1'b0));
      rd(8'h10, v);
      chk(v, 32'h0000_0000);
      wrap_up;
   end
endmodule
`default_nettype wire
